// File: design/rat_pkg.sv
// constants, register map and types of the repeater access timing block
package rat_pkg;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          DEB_UNIT_NS     = 2_000_000;
  localparam int          CYC_DEB_UNIT    = (DEB_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          UNITS_PER_100MS = 50;
  localparam int          TENTHS_PER_S    = 10;
  localparam int          S_PER_MIN       = 60;
  localparam logic [1:0]  TONE_ARM_S      = 2'h3;
  localparam logic [5:0]  XTO_HOLD_MIN    = 6'h3C;
  localparam logic [7:0]  SET_MAX         = 8'h4B;

  // ---------------------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  OFS_ACCESS      = 8'h00;
  localparam logic [7:0]  OFS_MODE        = 8'h04;
  localparam logic [7:0]  OFS_DEBOUNCE    = 8'h08;
  localparam logic [7:0]  OFS_TAIL        = 8'h0C;
  localparam logic [7:0]  OFS_XTAIL       = 8'h10;
  localparam logic [7:0]  OFS_TONE_HOLD   = 8'h14;
  localparam logic [7:0]  OFS_CALL_INT    = 8'h18;
  localparam logic [7:0]  OFS_TIMEOUT     = 8'h1C;
  localparam logic [7:0]  OFS_MSG_PER     = 8'h20;
  localparam logic [7:0]  OFS_STATUS      = 8'h24;

  // ---------------------------------------------------------------------------
  // field positions and values
  // ---------------------------------------------------------------------------
  localparam int          ACC_GATE_TONE   = 0;
  localparam int          ACC_RPT_TONE    = 1;
  localparam int          ACC_GTX_TONE    = 2;
  localparam int          ACC_XTO         = 3;
  localparam int          ACC_TONE_COS    = 5;
  localparam logic [7:0]  ACC_HOLD_VAL    = 8'h10;
  localparam int          MODE_XTAIL_EN   = 4;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  RST_ACCESS      = 8'h00;
  localparam logic [7:0]  RST_MODE        = 8'h00;
  localparam logic [7:0]  RST_DEBOUNCE    = 8'h00;
  localparam logic [7:0]  RST_TAIL        = 8'h0A;
  localparam logic [7:0]  RST_XTAIL       = 8'h00;
  localparam logic [7:0]  RST_TONE_HOLD   = 8'h00;
  localparam logic [7:0]  RST_CALL_INT    = 8'h0A;
  localparam logic [7:0]  RST_TIMEOUT     = 8'h03;
  localparam logic [7:0]  RST_MSG_PER     = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_KEYED = 4'h2,
    ST_TAIL  = 4'h4,
    ST_XTAIL = 4'h8
  } rat_state_type;

endpackage : rat_pkg

// File: design/rat_presc.sv
// free-running prescaler giving 2 ms, 100 ms, 1 s and 1 min ticks
`timescale 1ns/1ps
module rat_presc
  import rat_pkg::*;
#(
  parameter int CYC_UNIT = CYC_DEB_UNIT
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // ticks
  output logic      t2ms_o,
  output logic      t100ms_o,
  output logic      t1s_o,
  output logic      t1min_o
);

  localparam int CW = $clog2(CYC_UNIT + 1);

  generate
    if (CYC_UNIT < 2) begin : g_chk
      $error("rat_presc: CYC_UNIT must be at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [CW-1:0] c_unit;
    logic [5:0]    c_100;
    logic [3:0]    c_1s;
    logic [5:0]    c_min;
    logic          t2;
    logic          t100;
    logic          t1s;
    logic          t1m;
  } rat_presc_type;

  rat_presc_type r, n;

  always_comb begin
    n      = r;
    n.t2   = 1'b0;
    n.t100 = 1'b0;
    n.t1s  = 1'b0;
    n.t1m  = 1'b0;
    if (r.c_unit == CW'(CYC_UNIT - 1)) begin
      n.c_unit = '0;
      n.t2     = 1'b1;
      if (r.c_100 == 6'(UNITS_PER_100MS - 1)) begin
        n.c_100 = '0;
        n.t100  = 1'b1;
        if (r.c_1s == 4'(TENTHS_PER_S - 1)) begin
          n.c_1s = '0;
          n.t1s  = 1'b1;
          if (r.c_min == 6'(S_PER_MIN - 1)) begin
            n.c_min = '0;
            n.t1m   = 1'b1;
          end else begin
            n.c_min = r.c_min + 6'h01;
          end
        end else begin
          n.c_1s = r.c_1s + 4'h1;
        end
      end else begin
        n.c_100 = r.c_100 + 6'h01;
      end
    end else begin
      n.c_unit = r.c_unit + CW'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign t2ms_o   = r.t2;
  assign t100ms_o = r.t100;
  assign t1s_o    = r.t1s;
  assign t1min_o  = r.t1m;

endmodule : rat_presc

// File: design/rat_access.sv
// repeater access qualification, tail, timeout and interval timing with ahb-lite registers
//
// Function
// R1 - access bit 01: gateway receiver keys repeater transmitter only with its tone
// R2 - access bit 02: repeater receiver keys both transmitters only with tone
// R3 - access bit 04: repeater receiver needs tone for gateway, not for repeater
// R4 - access bit 08: tone held 3 s suspends timeout until 60 min after it ends
// R5 - entering extended timeout emits a two-beep request on repeater audio
// R6 - operator must not send continuous tone while extended timeout is active
// R7 - access value 10: each tone reopens the system for the tone-hold period
// R8 - access value 10 must be used alone
// R9 - access bit 20: repeater receiver tone acts as an alternative carrier detect
// R10 - access bit 20 must not combine with values 02, 03, 06, 07
// R11 - tone-hold period counts minutes, at most 4B
// R12 - carrier accepted only after open for the debounce setting, 2 ms units
// R13 - callsign interval counts minutes, at most 4B
// R14 - transmit timeout counts minutes, at most 4B
// R15 - settings are always sent as two hex digits
// R16 - after carrier drops a tail of setting times 100 ms runs, max 4B
// R17 - tail is lengthened while beeps or callsigns are playing
// R18 - timeout timer resets when carrier detect drops
// R19 - message period 00 disables, 01 to 4B repeats every 1 to 75 minutes
// R20 - message only when quiet, timer restarts on mute open, callsign follows
// R21 - extended tail of setting times 100 ms follows the tail, max 4B
// R22 - extended tail is zero when setting is 00 or enable flag clear
// R23 - extended tail enable is bit 10 of the mode setting
// R24 - all time units come from one free-running prescaler cleared by reset
// R25 - settings load defaults at reset and may be written at any time
`timescale 1ns/1ps
module rat_access
  import rat_pkg::*;
#(
  parameter int CYC_UNIT = CYC_DEB_UNIT
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // receivers
  input  wire logic        rpt_cos_i,
  input  wire logic        rpt_tone_i,
  input  wire logic        gate_cos_i,
  input  wire logic        gate_tone_i,
  // audio generator handshake
  input  wire logic        audio_busy_i,
  output logic             beep2_req_o,
  output logic             call_req_o,
  output logic             msg_req_o,
  // transmitters and state
  output logic             rpt_ptt_o,
  output logic             gate_ptt_o,
  output logic             timed_out_o
);

  typedef struct packed {
    logic [7:0]      access;
    logic [7:0]      mode;
    logic [7:0]      deb;
    logic [7:0]      tail;
    logic [7:0]      xtail;
    logic [7:0]      thold;
    logic [7:0]      call;
    logic [7:0]      tout;
    logic [7:0]      msg;
    logic [3:0]      s1;
    logic [3:0]      s2;
    logic [1:0][7:0] deb_cnt;
    rat_state_type   st;
    logic [7:0]      tail_cnt;
    logic [7:0]      to_min;
    logic            timed_out;
    logic [1:0]      tone_sec;
    logic            xto_act;
    logic [5:0]      xto_min;
    logic            hold_act;
    logic [7:0]      hold_min;
    logic [7:0]      call_min;
    logic            call_due;
    logic [7:0]      msg_min;
    logic            gate_used;
    logic            beep2;
    logic            call_req;
    logic            msg_req;
    logic            wr_pend;
    logic [7:0]      wr_ofs;
    logic [31:0]     rdata;
  } rat_state_vec_type;

  rat_state_vec_type r, n;
  logic              t2, t100, t1s, t1m;
  logic              rcos, rtone, gcos, gtone, tone_any;
  logic [1:0]        cos_eff, cd;
  logic              hold_mode, rt, gt, rkey, gkey, quiet;
  logic [31:0]       status;

  function automatic logic [7:0] f_clamp(input logic [7:0] v);
    return (v > SET_MAX) ? SET_MAX : v;
  endfunction : f_clamp

  // ---------------------------------------------------------------------------
  // time base
  // ---------------------------------------------------------------------------
  rat_presc #(
    .CYC_UNIT (CYC_UNIT)
  ) u_presc (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .t2ms_o    (t2),
    .t100ms_o  (t100),
    .t1s_o     (t1s),
    .t1min_o   (t1m)
  ); // see R24

  // ---------------------------------------------------------------------------
  // qualification
  // ---------------------------------------------------------------------------
  assign {gtone, gcos, rtone, rcos} = r.s2;
  assign tone_any   = rtone | gtone;
  assign cos_eff[0] = rcos | (r.access[ACC_TONE_COS] & rtone); // see R9
  assign cos_eff[1] = gcos;
  assign cd[0]      = cos_eff[0] & (r.deb_cnt[0] >= r.deb); // see R12
  assign cd[1]      = cos_eff[1] & (r.deb_cnt[1] >= r.deb); // see R12
  assign hold_mode  = (r.access == ACC_HOLD_VAL);
  assign rt         = rtone | r.hold_act; // see R7
  assign gt         = gtone | r.hold_act; // see R7
  // gateway receiver path: see R1, repeater receiver path: see R2 and R3
  assign rkey = ~r.timed_out &
                ((cd[0] & (~(r.access[ACC_RPT_TONE] | hold_mode) | rt)) |
                 (cd[1] & (~(r.access[ACC_GATE_TONE] | hold_mode) | gt)));
  assign gkey = ~r.timed_out &
                cd[0] & (~(r.access[ACC_RPT_TONE] | r.access[ACC_GTX_TONE] | hold_mode) | rt);
  assign quiet  = r.st[0] & ~(cd[0] | cd[1]);
  assign status = {20'h0, gkey, rkey, r.xto_act, r.hold_act, r.timed_out, r.call_due, cd, r.st};

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    n          = r;
    n.s1       = {gate_tone_i, gate_cos_i, rpt_tone_i, rpt_cos_i};
    n.s2       = r.s1;
    n.beep2    = 1'b0;
    n.call_req = 1'b0;
    n.msg_req  = 1'b0;
    n.wr_pend  = 1'b0;
    // register write in data phase, see R25
    if (r.wr_pend) begin
      unique case (r.wr_ofs)
        OFS_ACCESS:    n.access = hwdata_i[7:0];
        OFS_MODE:      n.mode   = hwdata_i[7:0];
        OFS_DEBOUNCE:  n.deb    = hwdata_i[7:0];
        OFS_TAIL:      n.tail   = f_clamp(hwdata_i[7:0]); // see R16
        OFS_XTAIL:     n.xtail  = f_clamp(hwdata_i[7:0]); // see R21
        OFS_TONE_HOLD: n.thold  = f_clamp(hwdata_i[7:0]); // see R11
        OFS_CALL_INT:  n.call   = f_clamp(hwdata_i[7:0]); // see R13
        OFS_TIMEOUT:   n.tout   = f_clamp(hwdata_i[7:0]); // see R14
        OFS_MSG_PER:   n.msg    = f_clamp(hwdata_i[7:0]); // see R19
        default:       n.wr_pend = 1'b0;
      endcase
    end
    // address phase; read data reflects a write finishing this cycle
    if (hsel_i && htrans_i[1] && hready_i) begin
      n.wr_pend = hwrite_i;
      n.wr_ofs  = haddr_i[7:0];
      unique case (haddr_i[7:0])
        OFS_ACCESS:    n.rdata = {24'h0, n.access};
        OFS_MODE:      n.rdata = {24'h0, n.mode};
        OFS_DEBOUNCE:  n.rdata = {24'h0, n.deb};
        OFS_TAIL:      n.rdata = {24'h0, n.tail};
        OFS_XTAIL:     n.rdata = {24'h0, n.xtail};
        OFS_TONE_HOLD: n.rdata = {24'h0, n.thold};
        OFS_CALL_INT:  n.rdata = {24'h0, n.call};
        OFS_TIMEOUT:   n.rdata = {24'h0, n.tout};
        OFS_MSG_PER:   n.rdata = {24'h0, n.msg};
        OFS_STATUS:    n.rdata = status;
        default:       n.rdata = 32'h0000_0000;
      endcase
    end
    // carrier debounce in 2 ms units
    for (int i = 0; i < 2; i++) begin
      if (!cos_eff[i]) begin
        n.deb_cnt[i] = 8'h00;
      end else if (t2 && r.deb_cnt[i] < r.deb) begin
        n.deb_cnt[i] = r.deb_cnt[i] + 8'h01; // see R12
      end
    end
    // transmit timeout
    if (!(cd[0] | cd[1])) begin
      n.to_min    = 8'h00; // see R18
      n.timed_out = 1'b0;
    end else begin
      if (r.st == ST_KEYED && t1m && !r.xto_act && r.to_min != 8'hFF) begin
        n.to_min = r.to_min + 8'h01; // see R14
      end
      if (r.tout != 8'h00 && r.to_min >= r.tout && !r.xto_act) begin
        n.timed_out = 1'b1;
      end
    end
    // extended timeout by held tone
    if (r.access[ACC_XTO] && tone_any) begin
      if (r.xto_act) begin
        n.xto_min = 6'h00;
      end
      if (t1s && r.tone_sec != TONE_ARM_S) begin
        n.tone_sec = r.tone_sec + 2'h1;
        if (r.tone_sec == TONE_ARM_S - 2'h1) begin
          n.xto_act = 1'b1; // see R4
          n.xto_min = 6'h00;
          n.beep2   = 1'b1; // see R5
        end
      end
    end else begin
      n.tone_sec = 2'h0;
      if (r.xto_act && t1m) begin
        if (r.xto_min == XTO_HOLD_MIN - 6'h01) begin
          n.xto_act = 1'b0; // see R4
        end else begin
          n.xto_min = r.xto_min + 6'h01;
        end
      end
    end
    // tone hold period
    if (!hold_mode) begin
      n.hold_act = 1'b0;
      n.hold_min = 8'h00;
    end else if (tone_any) begin
      n.hold_act = 1'b1; // see R7
      n.hold_min = 8'h00;
    end else if (r.hold_act && t1m) begin
      if ((r.hold_min + 8'h01) >= r.thold) begin
        n.hold_act = 1'b0; // see R11
      end else begin
        n.hold_min = r.hold_min + 8'h01;
      end
    end else if (r.hold_act && r.thold == 8'h00) begin
      n.hold_act = 1'b0;
    end
    // callsign interval
    if (t1m && r.call != 8'h00 && !r.call_due) begin
      if ((r.call_min + 8'h01) >= r.call) begin
        n.call_due = 1'b1; // see R13
        n.call_min = 8'h00;
      end else begin
        n.call_min = r.call_min + 8'h01;
      end
    end
    // periodic message
    if (!quiet) begin
      n.msg_min = 8'h00; // see R20
    end else if (t1m && r.msg != 8'h00) begin
      if ((r.msg_min + 8'h01) >= r.msg) begin
        n.msg_req  = 1'b1; // see R19
        n.call_req = 1'b1; // see R20
        n.call_due = 1'b0;
        n.call_min = 8'h00;
        n.msg_min  = 8'h00;
      end else begin
        n.msg_min = r.msg_min + 8'h01;
      end
    end
    // transmitter sequence
    if (gkey) begin
      n.gate_used = 1'b1;
    end
    unique case (r.st)
      ST_IDLE: begin
        n.gate_used = gkey;
        if (rkey) begin
          n.st = ST_KEYED;
        end
      end
      ST_KEYED: begin
        if (!rkey) begin
          n.st       = ST_TAIL;
          n.tail_cnt = r.tail; // see R16
          if (r.call_due) begin
            n.call_req = 1'b1;
            n.call_due = 1'b0;
            n.call_min = 8'h00;
          end
        end
      end
      ST_TAIL: begin
        if (rkey) begin
          n.st = ST_KEYED;
        end else if (r.tail_cnt == 8'h00 && !audio_busy_i) begin
          n.st       = ST_XTAIL; // see R17
          n.tail_cnt = r.mode[MODE_XTAIL_EN] ? r.xtail : 8'h00; // see R21 R22 R23
        end else if (t100 && !audio_busy_i && r.tail_cnt != 8'h00) begin
          n.tail_cnt = r.tail_cnt - 8'h01; // see R17
        end
      end
      ST_XTAIL: begin
        if (rkey) begin
          n.st = ST_KEYED;
        end else if (r.tail_cnt == 8'h00) begin
          n.st = ST_IDLE;
        end else if (t100) begin
          n.tail_cnt = r.tail_cnt - 8'h01; // see R21
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r        <= '0;
      r.access <= RST_ACCESS; // see R25
      r.mode   <= RST_MODE;
      r.deb    <= RST_DEBOUNCE;
      r.tail   <= RST_TAIL;
      r.xtail  <= RST_XTAIL;
      r.thold  <= RST_TONE_HOLD;
      r.call   <= RST_CALL_INT;
      r.tout   <= RST_TIMEOUT;
      r.msg    <= RST_MSG_PER;
      r.st     <= ST_IDLE;
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign hrdata_o    = r.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign beep2_req_o = r.beep2;
  assign call_req_o  = r.call_req;
  assign msg_req_o   = r.msg_req;
  assign rpt_ptt_o   = ~r.st[0];
  assign gate_ptt_o  = r.gate_used & ~r.st[0];
  assign timed_out_o = r.timed_out;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_key_drop;
    (r.st == ST_KEYED) && !rkey;
  endsequence

  sequence s_tail_end;
    (r.st == ST_TAIL) && !rkey && (r.tail_cnt == 8'h00) && !audio_busy_i;
  endsequence

  a_gate_tone_rpt: assert property ( // see R1
    (r.access[ACC_GATE_TONE] && !cd[0] && cd[1] && !gt) |-> !rkey)
    else $error("gateway receiver keyed repeater without tone");
  a_rpt_tone_both: assert property ( // see R2
    (r.access[ACC_RPT_TONE] && cd[0] && !rt) |-> !gkey)
    else $error("repeater receiver keyed gateway without tone");
  a_gtx_tone_only: assert property ( // see R3
    (r.access == 8'h04 && cd[0] && !r.timed_out) |-> (rkey && (gkey == rt)))
    else $error("bit 04 qualification wrong");
  a_xto_enter: assert property ( // see R4 R5
    $rose(r.xto_act) |-> r.beep2 && $past(tone_any) && $past(r.tone_sec) == (TONE_ARM_S - 2'h1))
    else $error("extended timeout entered without 3 s tone or beeps");
  a_hold_restart: assert property ( // see R7
    (hold_mode && tone_any) |=> (r.hold_act && r.hold_min == 8'h00))
    else $error("tone did not restart hold period");
  a_tone_as_cos: assert property ( // see R9
    (r.access[ACC_TONE_COS] && rtone) |-> cos_eff[0])
    else $error("tone not taken as carrier detect");
  a_set_max: assert property ( // see R11 R13 R14 R16 R21
    r.thold <= SET_MAX && r.call <= SET_MAX && r.tout <= SET_MAX && r.tail <= SET_MAX && r.xtail <= SET_MAX)
    else $error("setting above 4B");
  a_deb_zero: assert property ( // see R12
    (r.deb == 8'h00) |-> (cd == cos_eff))
    else $error("zero debounce delayed carrier");
  a_tail_load: assert property ( // see R16
    s_key_drop |=> (r.st == ST_TAIL) && r.tail_cnt == $past(r.tail))
    else $error("tail not loaded on carrier drop");
  a_tail_busy: assert property ( // see R17
    ((r.st == ST_TAIL) && !rkey && audio_busy_i) |=> (r.st == ST_TAIL) && $stable(r.tail_cnt))
    else $error("tail ran during audio");
  a_to_reset: assert property ( // see R18
    !(cd[0] | cd[1]) |=> (r.to_min == 8'h00) && !r.timed_out)
    else $error("timeout not reset on carrier drop");
  a_msg_quiet: assert property ( // see R19 R20
    r.msg_req |-> r.call_req && $past(quiet) && $past(r.msg) != 8'h00)
    else $error("message sent while busy or disabled");
  a_xtail_load: assert property ( // see R22 R23
    s_tail_end |=> (r.st == ST_XTAIL) && (r.tail_cnt == ($past(r.mode[MODE_XTAIL_EN]) ? $past(r.xtail) : 8'h00)))
    else $error("extended tail load wrong");

endmodule : rat_access

// File: test/rat_radio_model.sv
// far-side model: two receivers and the audio generator
`timescale 1ns/1ps
module rat_radio_model (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // requests and wanted receiver levels
  input  wire logic       beep2_req_i,
  input  wire logic       call_req_i,
  input  wire logic       msg_req_i,
  input  wire logic [3:0] rx_i,
  // receiver lines, audio state, beep count
  output logic      [3:0] rx_o,
  output logic            audio_busy_o,
  output logic      [7:0] beep_cnt_o
);
  // ---------------------------------------------------------------------------
  // receivers and audio playback
  // ---------------------------------------------------------------------------
  logic [5:0] play_r;
  assign audio_busy_o = (play_r != 6'h00);
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      play_r     <= 6'h00;
      beep_cnt_o <= 8'h00;
      rx_o       <= 4'h0;
    end else begin
      rx_o <= rx_i;
      if (beep2_req_i || call_req_i || msg_req_i) begin
        play_r <= 6'h14;
      end else if (play_r != 6'h00) begin
        play_r <= play_r - 6'h01;
      end
      if (beep2_req_i) begin
        beep_cnt_o <= beep_cnt_o + 8'h01;
      end
    end
  end
endmodule : rat_radio_model

// File: test/rat_access_bench.sv
// self-checking bench of the repeater access timing block
`timescale 1ns/1ps
module rat_access_bench;
  import rat_pkg::*;
  localparam int CU   = 2;
  localparam int T100 = UNITS_PER_100MS * CU;
  localparam logic [7:0] DFL [9] = '{RST_ACCESS, RST_MODE, RST_DEBOUNCE, RST_TAIL, RST_XTAIL,
                                     RST_TONE_HOLD, RST_CALL_INT, RST_TIMEOUT, RST_MSG_PER};
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        hsel_i    = 1'b0;
  logic [31:0] haddr_i   = 32'h0000_0000;
  logic [1:0]  htrans_i  = 2'h0;
  logic        hwrite_i  = 1'b0;
  logic [31:0] hwdata_i  = 32'h0000_0000;
  logic [3:0]  rx_want   = 4'h0;
  logic [31:0] hrdata_o;
  logic [31:0] q;
  logic [3:0]  rx;
  logic [7:0]  beeps;
  logic        hreadyout_o;
  logic        hresp_o;
  logic        beep2_req_o;
  logic        call_req_o;
  logic        msg_req_o;
  logic        rpt_ptt_o;
  logic        gate_ptt_o;
  logic        timed_out_o;
  logic        audio_busy;
  int          error_cnt = 0;
  int          n_checks  = 0;
  int          n_calls   = 0;
  int          n_msgs    = 0;

  always #4 clk_sys_i = ~clk_sys_i;

  // request pulses seen by the audio side
  always @(posedge clk_sys_i) begin
    if (call_req_o === 1'b1) n_calls <= n_calls + 1;
    if (msg_req_o === 1'b1) n_msgs <= n_msgs + 1;
  end

  rat_access #(.CYC_UNIT(CU)) dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .rpt_cos_i(rx[0]), .rpt_tone_i(rx[1]), .gate_cos_i(rx[2]),
    .gate_tone_i(rx[3]), .audio_busy_i(audio_busy), .beep2_req_o(beep2_req_o), .call_req_o(call_req_o),
    .msg_req_o(msg_req_o), .rpt_ptt_o(rpt_ptt_o), .gate_ptt_o(gate_ptt_o), .timed_out_o(timed_out_o));

  rat_radio_model model (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .beep2_req_i(beep2_req_o), .call_req_i(call_req_o),
    .msg_req_i(msg_req_o), .rx_i(rx_want), .rx_o(rx), .audio_busy_o(audio_busy), .beep_cnt_o(beeps));

  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    hsel_i   <= 1'b1;
    haddr_i  <= {24'h00_0000, a};
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
    chk("hresp", {31'h0, hresp_o}, 32'h0);
  endtask : bus

  task automatic rxs(input logic [3:0] v);
    @(posedge clk_sys_i);
    rx_want <= v;
  endtask : rxs

  task automatic pt(input int n, input logic e);
    repeat (n) @(posedge clk_sys_i);
    #1;
    chk("rpt_ptt", {31'h0, rpt_ptt_o}, {31'h0, e});
  endtask : pt

  task automatic idle;
    rxs(4'h0);
    for (int i = 0; i < 1000 && (rpt_ptt_o !== 1'b0 || gate_ptt_o !== 1'b0); i++) @(posedge clk_sys_i);
    chk("ptt released", {30'h0, rpt_ptt_o, gate_ptt_o}, 32'h0);
  endtask : idle

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    #680_000;
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      chk("default", q, {24'h0, DFL[i]});
    end
    bus(1'b1, 8'h28, 32'h0000_00FF);
    bus(1'b0, 8'h28, 32'h0);
    chk("unmapped", q, 32'h0);
    for (int i = 2; i < 9; i++) begin
      bus(1'b1, 8'(i * 4), 32'hFFFF_FFFF);
      bus(1'b0, 8'(i * 4), 32'h0);
      chk("clamp", q, (i == 2) ? 32'h0000_00FF : {24'h0, SET_MAX});
    end
    bus(1'b1, OFS_DEBOUNCE, 32'h0000_0000);
    bus(1'b1, OFS_TAIL, 32'h0000_0002);
    bus(1'b1, OFS_XTAIL, 32'h0000_0002);
    rxs(4'h1);
    pt(10, 1'b1);
    rxs(4'h0);
    pt(T100 - 10, 1'b1);
    pt(130, 1'b0);
    bus(1'b1, OFS_MODE, 32'h0000_0010);
    rxs(4'h1);
    pt(10, 1'b1);
    rxs(4'h0);
    pt(3 * T100 - 10, 1'b1);
    pt(T100 + 30, 1'b0);
    bus(1'b1, OFS_MODE, 32'h0000_0000);
    bus(1'b1, OFS_ACCESS, 32'h0000_0002);
    rxs(4'h1);
    pt(10, 1'b0);
    rxs(4'h3);
    pt(10, 1'b1);
    chk("gate_ptt", {31'h0, gate_ptt_o}, 32'h1);
    idle();
    bus(1'b1, OFS_ACCESS, 32'h0000_0004);
    rxs(4'h1);
    pt(10, 1'b1);
    chk("gate_ptt", {31'h0, gate_ptt_o}, 32'h0);
    idle();
    bus(1'b1, OFS_ACCESS, 32'h0000_0001);
    rxs(4'h4);
    pt(10, 1'b0);
    rxs(4'hC);
    pt(10, 1'b1);
    idle();
    bus(1'b1, OFS_ACCESS, 32'h0000_0010);
    rxs(4'h1);
    pt(10, 1'b0);
    rxs(4'h2);
    pt(10, 1'b0);
    rxs(4'h1);
    pt(10, 1'b1);
    idle();
    bus(1'b1, OFS_ACCESS, 32'h0000_0020);
    rxs(4'h2);
    pt(10, 1'b1);
    idle();
    bus(1'b1, OFS_ACCESS, 32'h0000_0000);
    bus(1'b1, OFS_DEBOUNCE, 32'h0000_0020);
    rxs(4'h1);
    pt(40, 1'b0);
    pt(60, 1'b1);
    idle();
    bus(1'b1, OFS_ACCESS, 32'h0000_0008);
    rxs(4'h3);
    repeat (4100) @(posedge clk_sys_i);
    rxs(4'h0);
    chk("two beeps", {24'h0, beeps}, 32'h1);
    idle();
    // mid-run reset, then one minute tick while keyed
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(negedge clk_sys_i);
    chk("reset outputs", {29'h0, rpt_ptt_o, gate_ptt_o, timed_out_o}, 32'h0);
    bus(1'b1, OFS_TIMEOUT, 32'h0000_0001);
    bus(1'b1, OFS_CALL_INT, 32'h0000_0001);
    rxs(4'h1);
    for (int i = 0; i < 70000 && timed_out_o !== 1'b1; i++) @(negedge clk_sys_i);
    chk("timed_out", {31'h0, timed_out_o}, 32'h1);
    repeat (4) @(negedge clk_sys_i);
    chk("call pulses", n_calls, 32'h1);
    chk("message pulses", n_msgs, 32'h0);
    rxs(4'h0);
    repeat (6) @(negedge clk_sys_i);
    chk("timeout cleared", {31'h0, timed_out_o}, 32'h0);
    final_report();
  end
endmodule : rat_access_bench
